//--- adcfmt_pkg.sv
package adcfmt_pkg;
  // ==================================================
  // Timing
  localparam int SAMPLE_PERIOD_NS = 320;
  localparam int SYS_PERIOD_NS    = 40;
  localparam int PHASE_STEPS      = SAMPLE_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [2:0] PHASE_LAST = 3'(PHASE_STEPS - 1);
  localparam logic [2:0] PHASE_HALF = 3'(PHASE_STEPS / 2);
  localparam logic [2:0] PHASE_ZERO = 3'h0;

  // ==================================================
  // Register bus map (index, byte address is four times the index)
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_PHASE  = 10'h002;
  localparam logic [9:0] IDX_MODE   = 10'h003;
  localparam logic [9:0] IDX_FORMAT = 10'h004;
  localparam logic [9:0] IDX_STATUS = 10'h005;

  // ==================================================
  // Output modes and drive table (units of 50 uA)
  localparam logic [1:0] MODE_FULL     = 2'h0;
  localparam logic [1:0] MODE_DDR_CMOS = 2'h1;
  localparam logic [1:0] MODE_DDR_LVDS = 2'h2;
  localparam logic [2:0] DRIVE_DEFAULT = 3'h4;
  localparam logic [7:0] DRIVE_TABLE [8] = '{8'h23, 8'h2a, 8'h32, 8'h3c, 8'h46, 8'h50, 8'h5a, 8'h46};

  // ==================================================
  // Codes
  localparam int RAW_W = 18;
  localparam logic signed [17:0] RAW_MAX  = 18'sh07fff;
  localparam logic signed [17:0] RAW_MIN  = 18'sh38000;
  localparam logic [15:0]        MSB_MASK = 16'h8000;
  localparam logic [15:0]        CODE_HI  = 16'h7fff;
  localparam logic [15:0]        CODE_LO  = 16'h8000;

  // ==================================================
  // Register layouts and carriers
  typedef struct packed {
    logic [3:0] rsvd;
    logic       invert;
    logic [1:0] shift;
    logic       stab;
  } adcfmt_phase_type;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       term;
    logic [2:0] cur;
    logic [1:0] mode;
  } adcfmt_mode_type;

  typedef struct packed {
    logic [5:0] rsvd;
    logic       rnd;
    logic       twos;
  } adcfmt_format_type;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       par;
    logic       flag2;
    logic       flag1;
    logic [1:0] mode;
  } adcfmt_status_type;

  typedef struct packed {
    logic [15:0] code;
    logic        flag;
  } adcfmt_word_type;

  typedef struct packed {
    logic       par;
    logic [1:0] mode;
    logic [1:0] shift;
    logic       invert;
    logic       stab;
    logic       twos;
    logic       rnd;
    logic [2:0] cur;
    logic       term;
  } adcfmt_cfg_type;

  localparam adcfmt_phase_type  PHASE_RESET  = '0;
  localparam adcfmt_mode_type   MODE_RESET   = '{rsvd: 2'h0, term: 1'b0, cur: DRIVE_DEFAULT, mode: MODE_FULL};
  localparam adcfmt_format_type FORMAT_RESET = '0;
endpackage

//--- adcfmt_core.sv
// How it works
// - Three output modes; serial registers or mode pin choose; pins cannot pick DDR CMOS
// - Full-rate CMOS drives sixteen bits per channel and one flag per channel
// - DDR CMOS muxes bit pairs 0/1..14/15 onto eight lanes per channel
// - DDR LVDS uses eight lanes per channel, one shared flag, one clock pair
// - Both DDR modes share one overflow output between the channels
// - Shared flag shows channel 2 while clock low, channel 1 while high
// - Overflow flag set out of range and delayed with its data word
// - LVDS drive defaults to 3.5 mA, seven selectable levels
// - Internal termination enable doubles the selected drive current
// - Full-rate data changes with clock falling edge; receiver latches on rising
// - DDR data changes on both clock edges
// - Clock shift of 0/45/90/135 degrees, only with the stabilizer on
// - Independent clock inversion, giving 0 to 315 degree shifts
// - Offset binary by default, two's complement when selected
// - Zero gives midscale; offset binary flips MSB; clamp with flag
// - Randomizer XORs LSB into the other fifteen bits only
module adcfmt_core
  import adcfmt_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    encode_clk_in,
  input  wire logic                    config_method_select,
  input  wire logic                    mode_select_pin,
  input  wire logic                    stabilizer_pin,
  input  wire logic signed [RAW_W-1:0] chan1_raw,
  input  wire logic signed [RAW_W-1:0] chan2_raw,
  output logic      [15:0]             chan1_data_bit,
  output logic      [15:0]             chan2_data_bit,
  output logic      [7:0]              chan1_bitpair_lane,
  output logic      [7:0]              chan2_bitpair_lane,
  output logic                         chan1_range_flag_out,
  output logic                         chan2_range_flag_out,
  output logic                         shared_range_flag_out,
  output logic                         forwarded_clock_true,
  output logic                         forwarded_clock_comp,
  output logic                         lvds_enable,
  output logic      [7:0]              lvds_drive_current,
  output logic                         lvds_term_enable
);

  // ==================================================
  // Helpers
  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [9:0] i;
    i = reg_index(a);
    is_mapped = (i == IDX_PHASE) || (i == IDX_MODE) || (i == IDX_FORMAT) || (i == IDX_STATUS);
  endfunction

  // Clamp, format and randomize one sample
  function automatic adcfmt_word_type format_word(input logic signed [RAW_W-1:0] raw,
                                                  input logic twos, input logic rnd);
    adcfmt_word_type w;
    w = '0;
    if (raw > RAW_MAX) begin
      w.code = CODE_HI;
      w.flag = 1'b1;
    end else if (raw < RAW_MIN) begin
      w.code = CODE_LO;
      w.flag = 1'b1;
    end else begin
      w.code = raw[15:0];
    end
    if (!twos) begin
      w.code = w.code ^ MSB_MASK;
    end
    if (rnd) begin
      w.code[15:1] = w.code[15:1] ^ {15{w.code[0]}};
    end
    format_word = w;
  endfunction

  function automatic logic is_ddr(input logic [1:0] m);
    is_ddr = (m == MODE_DDR_CMOS) || (m == MODE_DDR_LVDS);
  endfunction

  // ==================================================
  // Pin synchronisers
  logic [3:0] pin_meta, pin_sync;
  logic       enc_prev, enc_edge;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      enc_prev <= 1'b0;
    end else if (clk_en) begin
      pin_meta <= {encode_clk_in, config_method_select, mode_select_pin, stabilizer_pin};
      pin_sync <= pin_meta;
      enc_prev <= pin_sync[3];
    end
  end

  assign enc_edge = pin_sync[3] & ~enc_prev;

  // ==================================================
  // Registers
  adcfmt_phase_type  phase_reg, next_phase_reg;
  adcfmt_mode_type   mode_reg, next_mode_reg;
  adcfmt_format_type format_reg, next_format_reg;
  logic [31:0]       next_prdata;
  adcfmt_status_type status;
  adcfmt_cfg_type    eff;
  logic              wr_en;

  assign pready  = psel & penable & clk_en;
  assign pslverr = pready & ~is_mapped(paddr);
  assign wr_en   = pready & pwrite;

  always_comb begin
    next_phase_reg  = phase_reg;
    next_mode_reg   = mode_reg;
    next_format_reg = format_reg;
    next_prdata     = prdata;
    if (wr_en && reg_index(paddr) == IDX_PHASE) begin
      next_phase_reg      = adcfmt_phase_type'(pwdata[7:0]);
      next_phase_reg.rsvd = '0;
    end
    if (wr_en && reg_index(paddr) == IDX_MODE) begin
      next_mode_reg      = adcfmt_mode_type'(pwdata[7:0]);
      next_mode_reg.rsvd = '0;
    end
    if (wr_en && reg_index(paddr) == IDX_FORMAT) begin
      next_format_reg      = adcfmt_format_type'(pwdata[7:0]);
      next_format_reg.rsvd = '0;
    end
    // Read data is fetched in the setup cycle so the access phase needs no wait
    if (psel && !penable) begin
      case (reg_index(paddr))
        IDX_PHASE:  next_prdata = {24'h0, phase_reg};
        IDX_MODE:   next_prdata = {24'h0, mode_reg};
        IDX_FORMAT: next_prdata = {24'h0, format_reg};
        IDX_STATUS: next_prdata = {24'h0, status};
        default:    next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg  <= PHASE_RESET;
      mode_reg   <= MODE_RESET;
      format_reg <= FORMAT_RESET;
      prdata     <= 32'h0;
    end else if (clk_en) begin
      phase_reg  <= next_phase_reg;
      mode_reg   <= next_mode_reg;
      format_reg <= next_format_reg;
      prdata     <= next_prdata;
    end
  end

  // ==================================================
  // Effective configuration
  always_comb begin
    eff        = '0;
    eff.par    = pin_sync[2];
    if (eff.par) begin
      eff.mode = pin_sync[1] ? MODE_DDR_LVDS : MODE_FULL;
      eff.cur  = DRIVE_DEFAULT;
      eff.stab = pin_sync[0];
    end else begin
      eff.mode   = (mode_reg.mode > MODE_DDR_LVDS) ? MODE_FULL : mode_reg.mode;
      eff.shift  = phase_reg.shift;
      eff.invert = phase_reg.invert;
      eff.stab   = phase_reg.stab;
      eff.twos   = format_reg.twos;
      eff.rnd    = format_reg.rnd;
      eff.cur    = mode_reg.cur;
      eff.term   = mode_reg.term;
    end
  end

  // ==================================================
  // Sample pipeline and output stage
  logic [2:0]      cnt, next_cnt;
  logic [2:0]      shifted;
  adcfmt_word_type w1, w2, next_w1, next_w2;
  logic            base_q, next_base, hi_half;
  logic [15:0]     next_d1, next_d2;
  logic [7:0]      next_l1, next_l2;
  logic            next_f1, next_f2, next_fs, next_ck;
  logic [7:0]      next_cur;

  assign status = '{rsvd: 3'h0, par: eff.par, flag2: w2.flag, flag1: w1.flag, mode: eff.mode};

  always_comb begin
    next_cnt = (cnt == PHASE_LAST) ? cnt : cnt + 3'h1;
    next_w1  = w1;
    next_w2  = w2;
    if (enc_edge) begin
      next_cnt = PHASE_ZERO;
      next_w1  = format_word(chan1_raw, eff.twos, eff.rnd);
      next_w2  = format_word(chan2_raw, eff.twos, eff.rnd);
    end
    // Data timing follows the unshifted phase: data moves as it falls
    hi_half   = (cnt >= PHASE_HALF);
    next_base = hi_half;
    // Shift needs the stabilizer, since only then is the half period even
    shifted   = eff.stab ? 3'(cnt - {1'b0, eff.shift}) : cnt;
    next_ck   = (shifted >= PHASE_HALF) ^ eff.invert;
    next_d1   = 16'h0;
    next_d2   = 16'h0;
    next_l1   = 8'h0;
    next_l2   = 8'h0;
    next_f1   = 1'b0;
    next_f2   = 1'b0;
    next_fs   = 1'b0;
    if (is_ddr(eff.mode)) begin
      for (int i = 0; i < 8; i++) begin
        next_l1[i] = hi_half ? w1.code[2*i+1] : w1.code[2*i];
        next_l2[i] = hi_half ? w2.code[2*i+1] : w2.code[2*i];
      end
      next_fs = hi_half ? w1.flag : w2.flag;
    end else begin
      next_d1 = w1.code;
      next_d2 = w2.code;
      next_f1 = w1.flag;
      next_f2 = w2.flag;
    end
    next_cur = eff.term ? {DRIVE_TABLE[eff.cur][6:0], 1'b0} : DRIVE_TABLE[eff.cur];
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt                   <= PHASE_LAST;
      w1                    <= '0;
      w2                    <= '0;
      base_q                <= 1'b0;
      chan1_data_bit        <= 16'h0;
      chan2_data_bit        <= 16'h0;
      chan1_bitpair_lane    <= 8'h0;
      chan2_bitpair_lane    <= 8'h0;
      chan1_range_flag_out  <= 1'b0;
      chan2_range_flag_out  <= 1'b0;
      shared_range_flag_out <= 1'b0;
      forwarded_clock_true  <= 1'b0;
      forwarded_clock_comp  <= 1'b1;
      lvds_enable           <= 1'b0;
      lvds_drive_current    <= 8'h0;
      lvds_term_enable      <= 1'b0;
    end else if (clk_en) begin
      cnt                   <= next_cnt;
      w1                    <= next_w1;
      w2                    <= next_w2;
      base_q                <= next_base;
      chan1_data_bit        <= next_d1;
      chan2_data_bit        <= next_d2;
      chan1_bitpair_lane    <= next_l1;
      chan2_bitpair_lane    <= next_l2;
      chan1_range_flag_out  <= next_f1;
      chan2_range_flag_out  <= next_f2;
      shared_range_flag_out <= next_fs;
      forwarded_clock_true  <= next_ck;
      forwarded_clock_comp  <= ~next_ck;
      lvds_enable           <= (eff.mode == MODE_DDR_LVDS);
      lvds_drive_current    <= next_cur;
      lvds_term_enable      <= eff.term;
    end
  end

  // ==================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_pin_no_ddr_cmos;
    eff.par |-> eff.mode != MODE_DDR_CMOS;
  endproperty
  a_pin_no_ddr_cmos: assert property (p_pin_no_ddr_cmos) else $error("pin config chose DDR CMOS");
  property p_full_outputs;
    clk_en && eff.mode == MODE_FULL |=> chan1_data_bit == $past(w1.code) && chan2_range_flag_out == $past(w2.flag);
  endproperty
  a_full_outputs: assert property (p_full_outputs) else $error("full-rate outputs wrong");
  property p_lane_pair;
    clk_en && eff.mode == MODE_DDR_CMOS
      |=> chan1_bitpair_lane[0] == ($past(cnt) >= PHASE_HALF ? $past(w1.code[1]) : $past(w1.code[0]));
  endproperty
  a_lane_pair: assert property (p_lane_pair) else $error("bit pair lane wrong");
  property p_odd_high;
    clk_en && is_ddr(eff.mode) ##1 base_q |-> chan2_bitpair_lane[7] == $past(w2.code[15]);
  endproperty
  a_odd_high: assert property (p_odd_high) else $error("odd bit not in high half");
  property p_shared_flag;
    clk_en && is_ddr(eff.mode) |=> shared_range_flag_out == (base_q ? $past(w1.flag) : $past(w2.flag));
  endproperty
  a_shared_flag: assert property (p_shared_flag) else $error("shared flag channel order wrong");
  // Two full-rate cycles in a row, so a mode switch cannot pose as a data change
  property p_full_change_low;
    clk_en && eff.mode == MODE_FULL ##1 clk_en && eff.mode == MODE_FULL ##1 $changed(chan1_data_bit) |-> !base_q;
  endproperty
  a_full_change_low: assert property (p_full_change_low) else $error("data changed with clock high");
  property p_no_shift_without_stab;
    clk_en && !eff.stab && !eff.invert |=> forwarded_clock_true == base_q;
  endproperty
  a_no_shift_without_stab: assert property (p_no_shift_without_stab) else $error("clock shifted without stabilizer");
  property p_invert;
    clk_en && !eff.stab && eff.invert |=> forwarded_clock_true != base_q;
  endproperty
  a_invert: assert property (p_invert) else $error("clock not inverted");
  property p_overrange;
    clk_en && enc_edge && chan1_raw > RAW_MAX && !eff.rnd
      |=> w1.flag && w1.code == ($past(eff.twos) ? CODE_HI : CODE_HI ^ MSB_MASK);
  endproperty
  a_overrange: assert property (p_overrange) else $error("over range not clamped");
  property p_midscale;
    clk_en && enc_edge && chan1_raw == '0 && !eff.twos && !eff.rnd |=> w1.code == MSB_MASK && !w1.flag;
  endproperty
  a_midscale: assert property (p_midscale) else $error("zero not midscale");
  property p_rand_lsb;
    clk_en && enc_edge && eff.rnd |=> w1.flag || w1.code[0] == $past(chan1_raw[0]);
  endproperty
  a_rand_lsb: assert property (p_rand_lsb) else $error("randomizer touched LSB");
  property p_term_double;
    clk_en && eff.term |=> lvds_drive_current == {$past(DRIVE_TABLE[eff.cur][6:0]), 1'b0};
  endproperty
  a_term_double: assert property (p_term_double) else $error("termination did not double current");

  c_lvds: cover property (clk_en && eff.mode == MODE_DDR_LVDS && enc_edge);
  c_ddr_cmos_flag: cover property (clk_en && eff.mode == MODE_DDR_CMOS && shared_range_flag_out);
  c_shift_135: cover property (clk_en && eff.stab && eff.shift == 2'h3 && eff.invert);
  c_twos_rand: cover property (clk_en && enc_edge && eff.twos && eff.rnd);

endmodule

//--- adcfmt_rx_model.sv
module adcfmt_rx_model
  import adcfmt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        ddr,
  input  wire logic        rnd,
  input  wire logic [15:0] chan1_data_bit,
  input  wire logic [15:0] chan2_data_bit,
  input  wire logic [7:0]  chan1_bitpair_lane,
  input  wire logic [7:0]  chan2_bitpair_lane,
  input  wire logic        chan1_range_flag_out,
  input  wire logic        chan2_range_flag_out,
  input  wire logic        shared_range_flag_out,
  input  wire logic        forwarded_clock_true,
  output logic      [15:0] rx_word1,
  output logic      [15:0] rx_word2,
  output logic             rx_flag1,
  output logic             rx_flag2
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // Receiver capture
  logic [7:0]  ev1, ev2, od1, od2;
  logic [15:0] fr1, fr2;
  logic        fl1, fl2, sh1, sh2;
  logic        prev = 1'b0;

  function automatic logic [15:0] join_word(input logic [7:0] ev, input logic [7:0] od, input logic [15:0] fr);
    logic [15:0] w;
    for (int i = 0; i < 8; i++) begin
      w[2*i]   = ev[i];
      w[2*i+1] = od[i];
    end
    w = ddr ? w : fr;
    return rnd ? w ^ {{15{w[0]}}, 1'b0} : w;
  endfunction

  // A word is whole once the clock falls: both halves of one sample are held
  always @(posedge clk_sys) begin
    if (prev === 1'b1 && forwarded_clock_true === 1'b0) begin
      rx_word1 <= join_word(ev1, od1, fr1);
      rx_word2 <= join_word(ev2, od2, fr2);
      rx_flag1 <= ddr ? sh1 : fl1;
      rx_flag2 <= ddr ? sh2 : fl2;
    end
    if (forwarded_clock_true) begin
      fr1 = chan1_data_bit;
      fr2 = chan2_data_bit;
      fl1 = chan1_range_flag_out;
      fl2 = chan2_range_flag_out;
      od1 = chan1_bitpair_lane;
      od2 = chan2_bitpair_lane;
      sh1 = shared_range_flag_out;
    end else begin
      ev1 = chan1_bitpair_lane;
      ev2 = chan2_bitpair_lane;
      sh2 = shared_range_flag_out;
    end
    prev = forwarded_clock_true;
  end
endmodule

//--- test_dual_adc_output_formatter.sv
module test_dual_adc_output_formatter
  import adcfmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // Signals
  logic                    clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, encode_clk_in = 1'b0;
  logic                    psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0]       paddr = '0;
  logic [31:0]             pwdata = '0, prdata, rd_v;
  logic                    config_method_select = 1'b0, mode_select_pin = 1'b0, stabilizer_pin = 1'b0;
  logic signed [RAW_W-1:0] chan1_raw = '0, chan2_raw = '0;
  logic [15:0]             chan1_data_bit, chan2_data_bit, rx_word1, rx_word2;
  logic [7:0]              chan1_bitpair_lane, chan2_bitpair_lane, lvds_drive_current;
  logic                    chan1_range_flag_out, chan2_range_flag_out, shared_range_flag_out;
  logic                    forwarded_clock_true, forwarded_clock_comp, lvds_enable, lvds_term_enable;
  logic                    pready, pslverr, err_v, rx_flag1, rx_flag2;
  logic                    ddr_on = 1'b0, rnd_on = 1'b0, twos_on = 1'b0;
  int                      num_errors = 0, total_checks = 0, m, f, i, n, base;
  localparam logic signed [17:0] RAWS [8] = '{18'sh00000, 18'sh00001, 18'sh3ffff, 18'sh07fff,
                                              18'sh08000, 18'sh38000, 18'sh37fff, 18'sh01235};
  localparam logic [7:0] CUR [7] = '{8'h23, 8'h2a, 8'h32, 8'h3c, 8'h46, 8'h50, 8'h5a};

  always #20 clk_sys = ~clk_sys;

  // Odd offset keeps the sample clock out of phase with the system clock
  initial begin
    #7;
    forever #160 encode_clk_in = ~encode_clk_in;
  end

  adcfmt_core i_adcfmt_core (.clk_sys, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .encode_clk_in, .config_method_select, .mode_select_pin, .stabilizer_pin,
    .chan1_raw, .chan2_raw, .chan1_data_bit, .chan2_data_bit, .chan1_bitpair_lane, .chan2_bitpair_lane,
    .chan1_range_flag_out, .chan2_range_flag_out, .shared_range_flag_out, .forwarded_clock_true,
    .forwarded_clock_comp, .lvds_enable, .lvds_drive_current, .lvds_term_enable);

  adcfmt_rx_model i_adcfmt_rx_model (.clk_sys, .ddr(ddr_on), .rnd(rnd_on), .chan1_data_bit, .chan2_data_bit,
    .chan1_bitpair_lane, .chan2_bitpair_lane, .chan1_range_flag_out, .chan2_range_flag_out,
    .shared_range_flag_out, .forwarded_clock_true, .rx_word1, .rx_word2, .rx_flag1, .rx_flag2);

  // ==========
  // Tasks
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      num_errors++;
      print_verdict();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp, input logic exp_err);
    apb(1'b0, idx, 8'h00);
    check_val(rd_v, {24'h0, exp});
    check_val(err_v, exp_err);
  endtask

  function automatic logic [16:0] expect_word(input logic signed [17:0] raw, input logic twos);
    logic signed [17:0] c;
    c = (raw > RAW_MAX) ? RAW_MAX : (raw < RAW_MIN) ? RAW_MIN : raw;
    return {c[15:0] ^ (twos ? 16'h0000 : 16'h8000), c != raw};
  endfunction

  task automatic run_sample(input logic signed [17:0] r1, input logic signed [17:0] r2);
    logic [16:0] e1, e2;
    @(posedge clk_sys);
    e1 = expect_word(r1, twos_on);
    e2 = expect_word(r2, twos_on);
    chan1_raw <= r1;
    chan2_raw <= r2;
    repeat (4) @(posedge encode_clk_in);
    @(posedge clk_sys);
    check_val({rx_word1, rx_word2}, {e1[16:1], e2[16:1]});
    check_val({rx_flag1, rx_flag2}, {e1[0], e2[0]});
    if (ddr_on) check_val({chan1_data_bit, chan1_range_flag_out, chan2_range_flag_out}, 0);
    else check_val(chan1_data_bit, e1[16:1] ^ {{15{rnd_on & e1[1]}}, 1'b0});
  endtask

  // Every change of the data must land on a clock edge of the right kind
  task automatic edge_watch(input logic signed [17:0] r);
    logic [23:0] pd;
    logic        pc;
    int          k, hits;
    @(posedge clk_sys);
    chan1_raw <= r;
    pd = {chan1_data_bit, chan1_bitpair_lane};
    pc = forwarded_clock_true;
    hits = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      if ({chan1_data_bit, chan1_bitpair_lane} !== pd) begin
        hits++;
        check_val({pc, forwarded_clock_true}, ddr_on ? {pc, ~pc} : 2'b10);
      end
      pd = {chan1_data_bit, chan1_bitpair_lane};
      pc = forwarded_clock_true;
    end
    check_val(hits > 0, 1);
  endtask

  task automatic measure(output int cnt);
    logic p;
    repeat (2) begin
      @(posedge encode_clk_in);
      p = forwarded_clock_true;
      for (cnt = 1; cnt < 20; cnt++) begin
        @(posedge clk_sys);
        if (p === 1'b1 && forwarded_clock_true === 1'b0) break;
        p = forwarded_clock_true;
      end
    end
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check_val(lvds_drive_current, 8'h46);
    rd_chk(IDX_PHASE, 8'h00, 1'b0);
    rd_chk(IDX_MODE, 8'h10, 1'b0);
    rd_chk(IDX_FORMAT, 8'h00, 1'b0);
    rd_chk(10'h3ff, 8'h00, 1'b1);
    apb(1'b1, IDX_PHASE, 8'hff);
    rd_chk(IDX_PHASE, 8'h0f, 1'b0);
    for (m = 0; m < 3; m++) begin
      apb(1'b1, IDX_MODE, {3'h0, 3'h4, m[1:0]});
      apb(1'b1, IDX_PHASE, 8'h00);
      ddr_on <= (m != 0);
      check_val(lvds_enable, m == 2);
      for (f = 0; f < 4; f++) begin
        apb(1'b1, IDX_FORMAT, f[7:0]);
        twos_on <= f[0];
        rnd_on <= f[1];
        for (i = 0; i < 8; i++) run_sample(RAWS[i], RAWS[7 - i]);
      end
      edge_watch(18'sh05555);
    end
    for (i = 0; i < 14; i++) begin
      apb(1'b1, IDX_MODE, {2'h0, i >= 7, 3'(i % 7), 2'h2});
      repeat (2) @(posedge clk_sys);
      check_val({lvds_term_enable, lvds_drive_current}, {i >= 7, CUR[i % 7] << (i >= 7)});
    end
    apb(1'b1, IDX_MODE, 8'h10);
    ddr_on <= 1'b0;
    apb(1'b1, IDX_PHASE, 8'h01);
    measure(base);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, IDX_PHASE, {4'h0, i[2], i[1:0], 1'b1});
      measure(n);
      check_val((n - base) & 7, i);
    end
    apb(1'b1, IDX_PHASE, 8'h06);
    measure(n);
    check_val((n - base) & 7, 0);
    // Register asks for DDR CMOS; the pins must win and can only give full or LVDS
    apb(1'b1, IDX_MODE, 8'h11);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      config_method_select <= 1'b1;
      mode_select_pin <= i[0];
      repeat (4) @(posedge clk_sys);
      check_val({lvds_enable, lvds_drive_current}, {i[0], 8'h46});
      rd_chk(IDX_STATUS, {3'h0, 1'b1, 2'h0, i[0], 1'b0}, 1'b0);
    end
    // Clock enable low must freeze the forwarded clock and the lanes
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    n = {forwarded_clock_true, chan1_bitpair_lane};
    repeat (10) @(posedge clk_sys);
    check_val({forwarded_clock_true, chan1_bitpair_lane}, n);
    check_val(forwarded_clock_comp, !forwarded_clock_true);
    clk_en <= 1'b1;
    print_verdict();
  end
endmodule
